//--- rtl/fmpr_pkg.sv
// Constants shared by the fault mask and pin register bank
package fmpr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_COMM_STAT   = 8'h60;
  localparam logic [7:0]  IDX_SYS_STAT    = 8'h61;
  localparam logic [7:0]  IDX_CHIP_STAT   = 8'h62;
  localparam logic [7:0]  IDX_PIN_STAT    = 8'h63;
  localparam logic [7:0]  IDX_COMM_MASK   = 8'h68;
  localparam logic [7:0]  IDX_SYS_MASK    = 8'h6a;
  localparam logic [7:0]  IDX_CHIP_MASK   = 8'h6b;
  localparam logic [7:0]  IDX_FO_SELECT   = 8'h6e;
  localparam logic [7:0]  IDX_IRQ_STAT    = 8'h70;
  localparam logic [7:0]  IDX_IRQ_CLEAR   = 8'h71;
  localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'h72;
  localparam logic [7:0]  IDX_PIN_DIR     = 8'h78;
  localparam logic [7:0]  IDX_PIN_OUT     = 8'h79;
  localparam logic [7:0]  IDX_PIN_PU      = 8'h7a;
  localparam logic [7:0]  IDX_PIN_PD      = 8'h7b;
  localparam logic [7:0]  IDX_PIN_IN      = 8'h7c;
  localparam logic [7:0]  IDX_FLT_CFG     = 8'h7d;
  localparam int          ADDR_LSB        = 2;

  // Writable bits; everything else is reserved and holds zero
  localparam logic [15:0] COMM_WMASK      = 16'hffe1;
  localparam logic [15:0] SYS_WMASK       = 16'h00df;
  localparam logic [15:0] CHIP_WMASK      = 16'he000;
  localparam logic [15:0] FO_WMASK        = 16'hffc0;
  localparam logic [15:0] PIN_WMASK       = 16'h003f;
  localparam logic [15:0] FLT_CFG_WMASK   = 16'h007f;
  localparam logic [15:0] REG_RESET       = 16'h0000;

  // Field positions
  localparam int          STACK_FAULT_BIT = 0;
  localparam int          FLT_POL_BIT     = 6;
  localparam int          FO_CLASS_LSB    = 6;
  localparam int          NUM_CLASSES     = 10;
  localparam int          NUM_EXT_CLASSES = 6;
  localparam int          IRQ_BITS        = 4;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Startup window for the stack fault error, rounded down
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          STARTUP_NS      = 5000;
  localparam int          STARTUP_CYCLES  = STARTUP_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  STARTUP_COUNT   = 8'(STARTUP_CYCLES);
endpackage : fmpr_pkg

//--- rtl/fmpr_pin_if.sv
// Interface carrying raw and synchronised pin levels
`timescale 1ns/10ps
interface fmpr_pin_if #(parameter int NUM_PINS = 6);
  logic [NUM_PINS-1:0] pinRaw;
  logic [NUM_PINS-1:0] pinLevel;
  modport sync (input pinRaw, output pinLevel);
  modport core (output pinRaw, input pinLevel);
endinterface : fmpr_pin_if

//--- rtl/fmpr_pin_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/10ps
module fmpr_pin_sync #(
  parameter int NUM_PINS = 6
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  fmpr_pin_if.sync  pins
);
  logic [NUM_PINS-1:0] stage1;
  logic [NUM_PINS-1:0] stage2;

  // Pins are asynchronous; only stage2 is read downstream
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= pins.pinRaw;
      stage2 <= stage1;
    end
  end

  assign pins.pinLevel = stage2;
endmodule : fmpr_pin_sync

//--- rtl/fault_mask_and_pin_regs.sv
// Fault mask, fault output select and pin control register bank
//
// Behaviour
// - Comm mask bit 1 blocks that comm fault
// - Stack fault mask ignored during startup window
// - System mask bits 7,6,4..0 block faults
// - Chip mask bits 15..13, rest reserved
// - Reserved bits read zero, written zero
// - Select bits 15..6 pick fault output classes
// - Direction bit 1 makes pin output
// - Drive level only while direction is output
// - Pull-up bit enables pin pull-up
// - Pull-down bit enables pin pull-down
// - Input register returns synchronised pin levels
// - Selected pins raise fault at polarity level
// - Status bit clears on write one
`timescale 1ns/10ps
module fault_mask_and_pin_regs
  import fmpr_pkg::*;
#(
  parameter int ADDR_W   = 12,
  parameter int NUM_PINS = 6
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic [ADDR_W-1:0]          awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [ADDR_W-1:0]          araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic [15:0]                commFaultRaw,
  input  wire logic [7:0]                 sysFaultRaw,
  input  wire logic [15:0]                chipFaultRaw,
  input  wire logic [NUM_EXT_CLASSES-1:0] classFaultRaw,
  input  wire logic [NUM_PINS-1:0]        pinIn,
  output logic [NUM_PINS-1:0]             pinOut,
  output logic [NUM_PINS-1:0]             pinOeN,
  output logic [NUM_PINS-1:0]             pinPullUp,
  output logic [NUM_PINS-1:0]             pinPullDown,
  output logic                            faultOut,
  output logic                            irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                   awHeld, wHeld, doWrite;
  logic [7:0]             awIdx;
  logic [31:0]            wData;
  logic [3:0]             wStrb;
  logic [15:0]            commMask, sysMask, chipMask, foSelect;
  logic [15:0]            pinDir, pinDrive, pinPu, pinPd, fltCfg;
  logic [15:0]            commStat, sysStat, chipStat, pinStat;
  logic [IRQ_BITS-1:0]    irqStat, irqEn, irqEvents;
  logic [15:0]            commSet, sysSet, chipSet, pinSet, clrBits;
  logic [NUM_PINS-1:0]    pinLevel, pinActive;
  logic [NUM_CLASSES-1:0] faultClass;
  logic [7:0]             startCnt;
  logic                   startupActive;
  logic [7:0]             rdIdx;
  logic [31:0]            next_rdata;
  logic                   rdHit, wrHit;

  fmpr_pin_if #(.NUM_PINS(NUM_PINS)) pinBus ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  assign pinBus.pinRaw = pinIn;
  assign pinLevel      = pinBus.pinLevel;

  fmpr_pin_sync #(.NUM_PINS(NUM_PINS)) uSync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pins  (pinBus.sync)
  );

  // Byte-lane merge; reserved bits forced to zero on every write
  function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                             input logic [15:0] keep);
    mergeBytes = {wStrb[1] ? wData[15:8] : old[15:8],
                  wStrb[0] ? wData[7:0]  : old[7:0]} & keep;
  endfunction : mergeBytes

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign doWrite = awHeld && wHeld && !bvalid;
  assign clrBits = wData[15:0] & {{8{wStrb[1]}}, {8{wStrb[0]}}};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awready <= 1'b1;
      awHeld  <= 1'b0;
      awIdx   <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awHeld  <= 1'b1;
      awIdx   <= awaddr[ADDR_LSB +: 8];
    end else if (doWrite) begin
      awHeld  <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wready <= 1'b1;
      wHeld  <= 1'b0;
      wData  <= '0;
      wStrb  <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wHeld  <= 1'b1;
      wData  <= wdata;
      wStrb  <= wstrb;
    end else if (doWrite) begin
      wHeld  <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // Write decode; read-only and unknown indices answer with an error
  always_comb begin
    case (awIdx)
      IDX_COMM_STAT, IDX_SYS_STAT, IDX_CHIP_STAT, IDX_PIN_STAT,
      IDX_COMM_MASK, IDX_SYS_MASK, IDX_CHIP_MASK, IDX_FO_SELECT,
      IDX_IRQ_CLEAR, IDX_IRQ_ENABLE, IDX_PIN_DIR, IDX_PIN_OUT,
      IDX_PIN_PU, IDX_PIN_PD, IDX_FLT_CFG: wrHit = 1'b1;
      default:                             wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; reserved bits never store ones
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      commMask <= REG_RESET;
      sysMask  <= REG_RESET;
      chipMask <= REG_RESET;
      foSelect <= REG_RESET;
      pinDir   <= REG_RESET;
      pinDrive <= REG_RESET;
      pinPu    <= REG_RESET;
      pinPd    <= REG_RESET;
      fltCfg   <= REG_RESET;
      irqEn    <= '0;
    end else if (doWrite) begin
      case (awIdx)
        IDX_COMM_MASK:  commMask <= mergeBytes(commMask, COMM_WMASK);
        IDX_SYS_MASK:   sysMask  <= mergeBytes(sysMask, SYS_WMASK);
        IDX_CHIP_MASK:  chipMask <= mergeBytes(chipMask, CHIP_WMASK);
        IDX_FO_SELECT:  foSelect <= mergeBytes(foSelect, FO_WMASK);
        IDX_PIN_DIR:    pinDir   <= mergeBytes(pinDir, PIN_WMASK);
        IDX_PIN_OUT:    pinDrive <= mergeBytes(pinDrive, PIN_WMASK);
        IDX_PIN_PU:     pinPu    <= mergeBytes(pinPu, PIN_WMASK);
        IDX_PIN_PD:     pinPd    <= mergeBytes(pinPd, PIN_WMASK);
        IDX_FLT_CFG:    fltCfg   <= mergeBytes(fltCfg, FLT_CFG_WMASK);
        IDX_IRQ_ENABLE: irqEn    <= clrBits[IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup window: the stack fault mask does not hold until it closes
  assign startupActive = (startCnt != STARTUP_COUNT);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      startCnt <= '0;
    end else if (startupActive) begin
      startCnt <= startCnt + 8'h01;
    end
  end

  // Fault gating; detectors keep running, masked faults are just dropped
  always_comb begin
    commSet = commFaultRaw & ~commMask & COMM_WMASK;
    commSet[STACK_FAULT_BIT] = commFaultRaw[STACK_FAULT_BIT] &&
                               (!commMask[STACK_FAULT_BIT] || startupActive);
    sysSet  = {8'h00, sysFaultRaw} & ~sysMask & SYS_WMASK;
    chipSet = chipFaultRaw & ~chipMask & CHIP_WMASK;
  end

  // Pin fault inputs keep working even while the pin is driven
  assign pinActive = fltCfg[FLT_POL_BIT] ? pinLevel : ~pinLevel;
  assign pinSet    = {{(16-NUM_PINS){1'b0}},
                      fltCfg[NUM_PINS-1:0] & pinActive};

  ////////////////////////////////////////////////////////////////////////////
  // Latched status; a new fault wins over a write-one clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      commStat <= REG_RESET;
      sysStat  <= REG_RESET;
      chipStat <= REG_RESET;
      pinStat  <= REG_RESET;
    end else begin
      commStat <= (commStat & ~((doWrite && awIdx == IDX_COMM_STAT) ? clrBits : 16'h0000))
                  | commSet;
      sysStat  <= (sysStat & ~((doWrite && awIdx == IDX_SYS_STAT) ? clrBits : 16'h0000))
                  | sysSet;
      chipStat <= (chipStat & ~((doWrite && awIdx == IDX_CHIP_STAT) ? clrBits : 16'h0000))
                  | chipSet;
      pinStat  <= (pinStat & ~((doWrite && awIdx == IDX_PIN_STAT) ? clrBits : 16'h0000))
                  | pinSet;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: one sticky bit per status group, set wins over clear
  assign irqEvents = {|pinSet, |chipSet, |sysSet, |commSet};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irqStat <= '0;
      irq     <= 1'b0;
    end else begin
      irqStat <= (irqStat & ~((doWrite && awIdx == IDX_IRQ_CLEAR) ?
                              clrBits[IRQ_BITS-1:0] : {IRQ_BITS{1'b0}})) | irqEvents;
      irq     <= |(irqStat & irqEn);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault output: external classes plus the latched groups, per select bit
  assign faultClass = {classFaultRaw, |commStat, |sysStat, |chipStat, |pinStat};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      faultOut <= 1'b0;
    end else begin
      faultOut <= |(faultClass & foSelect[FO_CLASS_LSB +: NUM_CLASSES]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs; pin enable is active low, one cycle behind the register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pinOeN      <= '1;
      pinOut      <= '0;
      pinPullUp   <= '0;
      pinPullDown <= '0;
    end else begin
      pinOeN      <= ~pinDir[NUM_PINS-1:0];
      pinOut      <= pinDrive[NUM_PINS-1:0];
      pinPullUp   <= pinPu[NUM_PINS-1:0];
      pinPullDown <= pinPd[NUM_PINS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel; answer one cycle after the address is taken
  assign rdIdx = araddr[ADDR_LSB +: 8];

  always_comb begin
    next_rdata = '0;
    rdHit      = 1'b1;
    case (rdIdx)
      IDX_COMM_STAT:  next_rdata[15:0] = commStat;
      IDX_SYS_STAT:   next_rdata[15:0] = sysStat;
      IDX_CHIP_STAT:  next_rdata[15:0] = chipStat;
      IDX_PIN_STAT:   next_rdata[15:0] = pinStat;
      IDX_COMM_MASK:  next_rdata[15:0] = commMask;
      IDX_SYS_MASK:   next_rdata[15:0] = sysMask;
      IDX_CHIP_MASK:  next_rdata[15:0] = chipMask;
      IDX_FO_SELECT:  next_rdata[15:0] = foSelect;
      IDX_IRQ_STAT:   next_rdata[IRQ_BITS-1:0] = irqStat;
      IDX_IRQ_CLEAR:  next_rdata = '0;                    // Write-only
      IDX_IRQ_ENABLE: next_rdata[IRQ_BITS-1:0] = irqEn;
      IDX_PIN_DIR:    next_rdata[15:0] = pinDir;
      IDX_PIN_OUT:    next_rdata[15:0] = pinDrive;
      IDX_PIN_PU:     next_rdata[15:0] = pinPu;
      IDX_PIN_PD:     next_rdata[15:0] = pinPd;
      IDX_PIN_IN:     next_rdata[NUM_PINS-1:0] = pinLevel;
      IDX_FLT_CFG:    next_rdata[15:0] = fltCfg;
      default:        rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_comm_mask_gate: assert property ($rose(commStat[15]) |-> $past(!commMask[15]))
    else $error("masked comm fault was latched");
  a_stack_window: assert property (
    $rose(commStat[STACK_FAULT_BIT]) && $past(commMask[STACK_FAULT_BIT])
    |-> $past(startupActive))
    else $error("masked stack fault latched after startup");
  a_sys_mask_gate: assert property (
    $rose(sysStat[0]) |-> $past(sysFaultRaw[0] && !sysMask[0]))
    else $error("system fault latched without cause");
  a_chip_mask_gate: assert property ($rose(chipStat[13]) |-> $past(!chipMask[13]))
    else $error("masked chip fault was latched");
  a_reserved_zero: assert property (
    ((commMask & ~COMM_WMASK) == 16'h0000) && (chipMask[12:0] == 13'h0000)
    && ((foSelect & ~FO_WMASK) == 16'h0000))
    else $error("reserved bit holds a one");
  a_fault_select: assert property (
    (foSelect[FO_CLASS_LSB + 3] && |commStat) |=> faultOut)
    else $error("selected comm fault missing on fault output");
  a_pin_dir_drive: assert property (
    pinDir[0] && !(doWrite && awIdx == IDX_PIN_DIR) |=> ##1 !pinOeN[0])
    else $error("output pin not driven");
  a_pin_in_read: assert property (
    arvalid && arready && rdIdx == IDX_PIN_IN
    |=> rvalid && rdata[7:6] == 2'b00 && rdata[NUM_PINS-1:0] == $past(pinLevel))
    else $error("pin input readback wrong");
  a_pin_fault_set: assert property (
    fltCfg[0] && (pinLevel[0] == fltCfg[FLT_POL_BIT]) |=> pinStat[0])
    else $error("pin fault not latched");
  a_w1c_clear: assert property (
    doWrite && awIdx == IDX_SYS_STAT && clrBits[0] && !sysSet[0] |=> !sysStat[0])
    else $error("write one did not clear status");

  c_write_done: cover property (doWrite ##[1:4] (bvalid && bready));
  c_irq_raise:  cover property ($rose(irq));
  c_pin_fault:  cover property ($rose(pinStat[0]) ##[1:20] faultOut);
endmodule : fault_mask_and_pin_regs

//--- verification/fmpr_pin_model.sv
// Behavioural model of the circuitry hanging on the six general purpose pins
`timescale 1ns/10ps
module fmpr_pin_model (
  input  wire logic       mclk,
  input  wire logic [5:0] pinOut,
  input  wire logic [5:0] pinOeN,
  input  wire logic [5:0] pinPullUp,
  input  wire logic [5:0] pinPullDown,
  input  wire logic [5:0] extDrive,
  input  wire logic [5:0] extLevel,
  output logic      [5:0] pinIn
);
  logic [5:0] floatLevel;
  // A pin nobody holds wanders every cycle, so a stale value never passes
  always_ff @(posedge mclk) begin
    floatLevel <= (floatLevel === 6'h15) ? 6'h2a : 6'h15;
  end
  // Device driver wins, then the outside driver, then the pulls
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pinOeN[i]) pinIn[i] = pinOut[i];
      else if (extDrive[i]) pinIn[i] = extLevel[i];
      else if (pinPullUp[i] && pinPullDown[i]) pinIn[i] = floatLevel[i];
      else if (pinPullUp[i]) pinIn[i] = 1'b1;
      else if (pinPullDown[i]) pinIn[i] = 1'b0;
      else pinIn[i] = floatLevel[i];
    end
  end
endmodule : fmpr_pin_model

//--- verification/fault_mask_and_pin_regs_tb.sv
// Self-checking bench for the fault mask and pin register bank
`timescale 1ns/10ps
`define CHK(a, e, m) begin checksDone++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t %s: got %h exp %h", $time, m, a, e); end end
module fault_mask_and_pin_regs_tb;
  import fmpr_pkg::*;
  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, faultOut, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] commFaultRaw, chipFaultRaw;
  logic [7:0]  sysFaultRaw;
  logic [5:0]  classFaultRaw, pinIn, pinOut, pinOeN, pinPullUp, pinPullDown;
  logic [5:0]  extDrive, extLevel;
  int          miscompares, checksDone;
  localparam logic [7:0] regIdx [9] = '{IDX_COMM_MASK, IDX_SYS_MASK, IDX_CHIP_MASK,
    IDX_FO_SELECT, IDX_PIN_DIR, IDX_PIN_OUT, IDX_PIN_PU, IDX_PIN_PD, IDX_PIN_IN};
  localparam logic [15:0] regWm [8] = '{COMM_WMASK, SYS_WMASK, CHIP_WMASK, FO_WMASK,
    PIN_WMASK, PIN_WMASK, PIN_WMASK, PIN_WMASK};

  fault_mask_and_pin_regs fault_mask_and_pin_regs_inst (.mclk(mclk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .commFaultRaw(commFaultRaw), .sysFaultRaw(sysFaultRaw),
    .chipFaultRaw(chipFaultRaw), .classFaultRaw(classFaultRaw), .pinIn(pinIn),
    .pinOut(pinOut), .pinOeN(pinOeN), .pinPullUp(pinPullUp), .pinPullDown(pinPullDown),
    .faultOut(faultOut), .irq(irq));
  fmpr_pin_model fmpr_pin_model_inst (.mclk(mclk), .pinOut(pinOut), .pinOeN(pinOeN),
    .pinPullUp(pinPullUp), .pinPullDown(pinPullDown), .extDrive(extDrive),
    .extLevel(extLevel), .pinIn(pinIn));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, reached from the main sequence or a hung wait
  task testDone;
    $display("checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : testDone

  task hang;
    miscompares++;
    $display("[FAIL] %0t bus answer never came", $time);
    testDone();
  endtask : hang

  // Write one word; address and data are offered together and released when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge mclk);
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 64) hang();
    `CHK(bresp, er, "write response")
  endtask : wr

  // Read one word; rready stays up until the answer is sampled
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge mclk);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 64) hang();
    `CHK(rdata, ed, "read data")
    `CHK(rresp, er, "read response")
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'hf;
    commFaultRaw = 16'h0; sysFaultRaw = 8'h0; chipFaultRaw = 16'h0; classFaultRaw = 6'h0;
    // Pins held low from outside so the reset readback of the input register is defined
    extDrive = 6'h3f; extLevel = 6'h0; miscompares = 0; checksDone = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset state, done early to stay inside the startup window
    for (int i = 0; i < 9; i++) rd(regIdx[i], 32'h0);
    `CHK(pinOeN, 6'h3f, "pins released after reset")
    extDrive <= 6'h00;
    // Stack fault latches through its mask only during startup
    wr(IDX_COMM_MASK, 32'h1);
    commFaultRaw <= 16'h0001;
    repeat (3) @(posedge mclk);
    rd(IDX_COMM_STAT, 32'h1);
    commFaultRaw <= 16'h0000;
    repeat (130) @(posedge mclk);
    wr(IDX_COMM_STAT, 32'h1);
    commFaultRaw <= 16'h0001;
    repeat (3) @(posedge mclk);
    rd(IDX_COMM_STAT, 32'h0);
    commFaultRaw <= 16'h0000;
    $display("test startup window done");
    // Writable bits of every mask, select, direction, drive and pull register; pulls cleared before the next one
    for (int i = 0; i < 8; i++) begin
      wr(regIdx[i], 32'hffffffff);
      rd(regIdx[i], {16'h0, regWm[i]});
      wr(regIdx[i], 32'h0);
    end
    rd(8'h00, 32'h0, RESP_SLVERR);
    wr(IDX_PIN_IN, 32'h3f, RESP_SLVERR);
    $display("test register access done");
    // Pin drive, pulls and readback
    wr(IDX_PIN_OUT, 32'h15);
    wr(IDX_PIN_DIR, 32'h3f);
    repeat (4) @(posedge mclk);
    `CHK(pinOeN, 6'h00, "pins driven")
    `CHK(pinOut, 6'h15, "drive level")
    rd(IDX_PIN_IN, 32'h15);
    wr(IDX_PIN_DIR, 32'h0f);
    wr(IDX_PIN_PU, 32'h30);
    repeat (4) @(posedge mclk);
    `CHK(pinOeN, 6'h30, "upper pins released")
    `CHK(pinPullUp, 6'h30, "pull-up outputs")
    rd(IDX_PIN_IN, 32'h35);
    wr(IDX_PIN_PU, 32'h0);
    wr(IDX_PIN_PD, 32'h30);
    repeat (4) @(posedge mclk);
    `CHK(pinPullDown, 6'h30, "pull-down outputs")
    rd(IDX_PIN_IN, 32'h05);
    wr(IDX_PIN_PD, 32'h0);
    wr(IDX_PIN_DIR, 32'h0);
    // Pin fault input, high sense
    extDrive <= 6'h01;
    extLevel <= 6'h01;
    wr(IDX_FLT_CFG, 32'h41);
    repeat (4) @(posedge mclk);
    rd(IDX_PIN_STAT, 32'h01);
    wr(IDX_FLT_CFG, 32'h0);
    wr(IDX_PIN_STAT, 32'h01);
    rd(IDX_PIN_STAT, 32'h0);
    extDrive <= 6'h00;
    $display("test pins done");
    // Interrupt status is sticky: startup stack fault and pin fault still show
    rd(IDX_IRQ_STAT, 32'h9);
    wr(IDX_IRQ_CLEAR, 32'hf);
    // Masked faults stay silent, unmasked ones latch and raise the outputs
    wr(IDX_COMM_MASK, 32'hffff);
    wr(IDX_SYS_MASK, 32'hff);
    wr(IDX_CHIP_MASK, 32'hffff);
    wr(IDX_FO_SELECT, 32'h0380);
    commFaultRaw <= 16'h8020;
    sysFaultRaw <= 8'h81;
    chipFaultRaw <= 16'h8000;
    repeat (4) @(posedge mclk);
    rd(IDX_COMM_STAT, 32'h0);
    rd(IDX_SYS_STAT, 32'h0);
    rd(IDX_CHIP_STAT, 32'h0);
    rd(IDX_IRQ_STAT, 32'h0);
    `CHK(faultOut, 1'b0, "fault output while masked")
    wr(IDX_COMM_MASK, 32'h0020);
    wr(IDX_SYS_MASK, 32'h01);
    wr(IDX_CHIP_MASK, 32'h0);
    repeat (3) @(posedge mclk);
    rd(IDX_COMM_STAT, 32'h8000);
    rd(IDX_SYS_STAT, 32'h80);
    rd(IDX_CHIP_STAT, 32'h8000);
    rd(IDX_IRQ_STAT, 32'h7);
    `CHK(irq, 1'b0, "interrupt disabled")
    `CHK(faultOut, 1'b1, "fault output selected")
    commFaultRaw <= 16'h0;
    sysFaultRaw <= 8'h0;
    chipFaultRaw <= 16'h0;
    wr(IDX_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1, "interrupt enabled")
    wr(IDX_COMM_STAT, 32'h0);
    rd(IDX_COMM_STAT, 32'h8000);
    wr(IDX_COMM_STAT, 32'h8000);
    wr(IDX_SYS_STAT, 32'h80);
    wr(IDX_CHIP_STAT, 32'h8000);
    rd(IDX_COMM_STAT, 32'h0);
    `CHK(faultOut, 1'b0, "fault output cleared")
    wr(IDX_IRQ_CLEAR, 32'hf);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0, "interrupt cleared")
    rd(IDX_IRQ_STAT, 32'h0);
    // Class faults reach the output only when selected
    wr(IDX_FO_SELECT, 32'h8000);
    classFaultRaw <= 6'h20;
    repeat (3) @(posedge mclk);
    `CHK(faultOut, 1'b1, "cell class selected")
    classFaultRaw <= 6'h10;
    repeat (3) @(posedge mclk);
    `CHK(faultOut, 1'b0, "cell class excluded")
    $display("test faults done");
    testDone();
  end
endmodule : fault_mask_and_pin_regs_tb
